// ### design/mfm_fault_monitor.v
// Fault and protection monitor for a three-phase inverter drive, APB slave.
// Assumes sample inputs synchronous to pclk and held stable between ticks.
//
// Notes on behaviour
// - A low on hw_oc_n releases all six gate pins to high impedance at once.
// - Each control tick, any phase current beyond 7 A raises an overcurrent fault.
// - Each control tick, bus voltage above 420 V raises an overvoltage fault.
// - Each control tick, bus voltage below 0 V raises an undervoltage fault.
// - Each control tick, speed beyond 490 rad/s electrical raises a speed fault.
// - Each main-loop pass, resultant current of 6 A or more raises an overload fault.
// - Each main-loop pass, 2000 rpm or more with at most 1 A raises a dry-running fault.
// - Seven protection faults are kept apart and each alone stops the gate outputs.
// - The controller has stopped, running, timed running, timed waiting and fault modes.
// - Every main-loop pass services the watchdog.
// - On emergency stop all six gate outputs go to their inactive level.
// - Bus voltage codes span 0 V to 686.5 V over 0x000 to 0xfff.
// - Phase current codes span -50 A to 50 A over 0x000 to 0xfff, mid-scale zero.
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "mfm_defines.vh"

module mfm_fault_monitor #(
    parameter [15:0] TICK_CYCLES = `MFM_TICK_CYCLES,
    parameter [15:0] LOOP_CYCLES = `MFM_LOOP_CYCLES
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output reg         pslverr,
    input  wire        hw_oc_n,
    input  wire [11:0] cur_u,
    input  wire [11:0] cur_v,
    input  wire [11:0] cur_w,
    input  wire [11:0] bus_volt,
    input  wire [15:0] speed_rads,
    input  wire [15:0] speed_rpm,
    input  wire [11:0] cur_result,
    input  wire [5:0]  pwm_in,
    output reg  [5:0]  pwm_out,
    output wire [5:0]  pwm_oe,
    output reg         wdt_kick,
    output wire        irq
);
    // Limit codes, derived from the converter scales.
    localparam integer OC_INT  = (`MFM_OC_LIMIT_A * `MFM_ADC_FULL) / `MFM_I_SPAN_A;
    localparam integer OV_INT  = (`MFM_OV_LIMIT_DV * `MFM_ADC_FULL) / `MFM_V_SPAN_DV;
    localparam integer UV_INT  = (`MFM_UV_LIMIT_DV * `MFM_ADC_FULL) / `MFM_V_SPAN_DV;
    // A "6 A or more" bound rounds up so that no code below 6 A trips it.
    localparam integer OL_INT  = (`MFM_OL_LIMIT_A * `MFM_ADC_FULL + `MFM_I_SPAN_A - 1)
                                 / `MFM_I_SPAN_A;
    localparam integer DRY_INT = (`MFM_DRY_I_A * `MFM_ADC_FULL) / `MFM_I_SPAN_A;
    localparam [11:0]  OC_CODE  = OC_INT[11:0];
    localparam [11:0]  OV_CODE  = OV_INT[11:0];
    localparam [12:0]  UV_CODE  = UV_INT[12:0];
    localparam [11:0]  OL_CODE  = OL_INT[11:0];
    localparam [11:0]  DRY_CODE = DRY_INT[11:0];
    localparam integer SPD_INT  = `MFM_SPD_LIMIT_RADS;
    localparam integer RPM_INT  = `MFM_DRY_RPM;
    localparam [15:0]  SPD_LIM  = SPD_INT[15:0];
    localparam [15:0]  RPM_LIM  = RPM_INT[15:0];

    // Application modes, one-hot.
    localparam [4:0] ST_STOP  = 5'h01;
    localparam [4:0] ST_RUN   = 5'h02;
    localparam [4:0] ST_TRUN  = 5'h04;
    localparam [4:0] ST_TWAIT = 5'h08;
    localparam [4:0] ST_FAULT = 5'h10;

    // Magnitude of a mid-scale coded phase current.
    function [11:0] cur_mag;
        input [11:0] code;
        begin
            if (code >= `MFM_ADC_MID)
                cur_mag = code - `MFM_ADC_MID;
            else
                cur_mag = `MFM_ADC_MID - code;
        end
    endfunction

    // Word-aligned address match within the block's decode.
    function hit;
        input [11:0] a;
        input [11:0] off;
        begin
            hit = (a[11:2] == off[11:2]);
        end
    endfunction

    reg [`MFM_OP_W-1:0]   oper_q;
    reg                   err_rst_prev_q;
    reg [`MFM_NFAULT-1:0] fault_q;
    reg [`MFM_NFAULT-1:0] irq_stat_q;
    reg [`MFM_NFAULT-1:0] irq_mask_q;
    reg [15:0]            timer_per_q;
    reg [15:0]            timer_cnt_q;
    reg [4:0]             state_q;
    reg [4:0]             state_d;
    reg                   gate_en_q;

    // Control tick for the sampled checks and main-loop tick for the slower ones.
    wire ctl_tick;
    wire loop_tick;

    mfm_tick_gen #(
        .COUNT (TICK_CYCLES)
    ) u_ctl_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .tick_q  (ctl_tick)
    );

    mfm_tick_gen #(
        .COUNT (LOOP_CYCLES)
    ) u_loop_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .tick_q  (loop_tick)
    );

    // APB decode. The slave never waits, so every access ends in its first access cycle.
    wire setup_ph = psel & ~penable;
    wire wr_acc   = psel & penable & pwrite;
    wire sel_oper = hit(paddr, `MFM_ADDR_OPER);
    wire sel_flt  = hit(paddr, `MFM_ADDR_FAULT);
    wire sel_stat = hit(paddr, `MFM_ADDR_IRQ_STAT);
    wire sel_mask = hit(paddr, `MFM_ADDR_IRQ_MASK);
    wire sel_mode = hit(paddr, `MFM_ADDR_MODE);
    wire sel_tmr  = hit(paddr, `MFM_ADDR_TIMER);
    wire mapped   = sel_oper | sel_flt | sel_stat | sel_mask | sel_mode | sel_tmr;

    // Write strobes, one per writable word; the other words ignore writes.
    wire wr_oper  = wr_acc & sel_oper;
    wire wr_stat  = wr_acc & sel_stat;
    wire wr_mask  = wr_acc & sel_mask;
    wire wr_tmr   = wr_acc & sel_tmr;

    assign pready = 1'b1;

    // Fault detection.
    wire [11:0] mag_u = cur_mag(cur_u);
    wire [11:0] mag_v = cur_mag(cur_v);
    wire [11:0] mag_w = cur_mag(cur_w);
    // Speed is signed, so both directions of rotation meet the same limit.
    wire [15:0] spd_mag = speed_rads[15] ? (~speed_rads + 16'd1) : speed_rads;

    reg [`MFM_NFAULT-1:0] det;
    always @* begin
        det = {`MFM_NFAULT{1'b0}};
        // Sampled level of the emergency input; the pins themselves react without it.
        det[`MFM_F_HW_OC] = ~hw_oc_n;
        // Currents scale over the full span, so the limit is a distance from mid-scale.
        det[`MFM_F_OC] = ctl_tick & ((mag_u > OC_CODE) | (mag_v > OC_CODE) |
                                     (mag_w > OC_CODE));
        det[`MFM_F_OV] = ctl_tick & (bus_volt > OV_CODE);
        // The code cannot go below 0 V, so this check only trips if the limit is raised.
        det[`MFM_F_UV] = ctl_tick & ({1'b0, bus_volt} < UV_CODE);
        det[`MFM_F_SPEED] = ctl_tick & (spd_mag > SPD_LIM);
        det[`MFM_F_OVERLOAD] = loop_tick & (cur_result >= OL_CODE);
        det[`MFM_F_DRY] = loop_tick & (speed_rpm >= RPM_LIM) &
                          (cur_result <= DRY_CODE);
    end

    wire err_reset = oper_q[`MFM_OP_ERR_RESET] & ~err_rst_prev_q;

    // Control registers written by software.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oper_q         <= `MFM_OPER_RST;
            err_rst_prev_q <= 1'b0;
            irq_mask_q     <= `MFM_MASK_RST;
            timer_per_q    <= `MFM_TIMER_RST;
        end else begin
            err_rst_prev_q <= oper_q[`MFM_OP_ERR_RESET];
            if (wr_oper) begin
                oper_q <= pwdata[`MFM_OP_W-1:0];
            end
            if (wr_mask) begin
                irq_mask_q <= pwdata[`MFM_NFAULT-1:0];
            end
            if (wr_tmr) begin
                timer_per_q <= pwdata[15:0];
            end
        end
    end

    // Fault latch. A fault seen in the reset cycle survives it, so a cause that
    // persists re-latches by its next check and the gates never pulse on.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_q <= {`MFM_NFAULT{1'b0}};
        end else if (err_reset) begin
            fault_q <= det;
        end else begin
            fault_q <= fault_q | det;
        end
    end

    // Interrupt status: a new event wins over a write-one-to-clear in the same cycle.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= {`MFM_NFAULT{1'b0}};
        end else if (wr_stat) begin
            irq_stat_q <= (irq_stat_q & ~pwdata[`MFM_NFAULT-1:0]) | det;
        end else begin
            irq_stat_q <= irq_stat_q | det;
        end
    end

    // Level interrupt: high while any unmasked status bit is set.
    assign irq = |(irq_stat_q & irq_mask_q);

    // Application mode sequencing.
    wire any_fault = |fault_q;
    wire op_run    = oper_q[`MFM_OP_RUN];
    wire op_timed  = oper_q[`MFM_OP_TIMED];
    // A timed phase ends at the first loop tick on which its count reaches the period.
    wire timer_end = loop_tick & (timer_cnt_q >= timer_per_q);

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_STOP: begin
                if (op_run)
                    state_d = op_timed ? ST_TRUN : ST_RUN;
            end
            ST_RUN: begin
                if (!op_run)
                    state_d = ST_STOP;
                else if (op_timed)
                    state_d = ST_TRUN;
            end
            ST_TRUN: begin
                if (!op_run)
                    state_d = ST_STOP;
                else if (!op_timed)
                    state_d = ST_RUN;
                else if (timer_end)
                    state_d = ST_TWAIT;
            end
            ST_TWAIT: begin
                if (!op_run)
                    state_d = ST_STOP;
                else if (!op_timed)
                    state_d = ST_RUN;
                else if (timer_end)
                    state_d = ST_TRUN;
            end
            ST_FAULT: begin
                // Leaving needs the run bit low too, so the motor never restarts by itself.
                if (!any_fault && !op_run)
                    state_d = ST_STOP;
            end
            default: begin
                state_d = ST_STOP;
            end
        endcase
        if (any_fault)
            state_d = ST_FAULT;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_STOP;
        end else begin
            state_q <= state_d;
        end
    end

    // Timed-phase length in loop ticks; it restarts on every mode change.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_cnt_q <= 16'h0000;
        end else if (state_d != state_q) begin
            timer_cnt_q <= 16'h0000;
        end else if (loop_tick) begin
            timer_cnt_q <= timer_cnt_q + 16'd1;
        end
    end

    // Gate outputs: driven inactive on any latched fault, released on the emergency pin.
    wire gate_ok = ((state_q == ST_RUN) | (state_q == ST_TRUN)) & ~any_fault & ~(|det);

    // The pattern lags pwm_in by one clock, the price of a pin that cannot glitch.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_en_q <= 1'b0;
            pwm_out   <= 6'h00;
        end else begin
            gate_en_q <= gate_ok;
            pwm_out   <= gate_ok ? pwm_in : 6'h00;
        end
    end

    // Watchdog service pulse, one per main-loop pass; a stalled loop lets it expire.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_kick <= 1'b0;
        end else begin
            wdt_kick <= loop_tick;
        end
    end

    // Combinational so that the pins let go in the same cycle as the emergency input.
    assign pwm_oe = hw_oc_n ? 6'h3f : 6'h00;

    // Read multiplexer; unmapped words read as zero.
    reg [31:0] rd_word;
    always @* begin
        rd_word = 32'h0000_0000;
        if (sel_oper) begin
            rd_word[`MFM_OP_W-1:0] = oper_q;
        end else if (sel_flt) begin
            rd_word[`MFM_NFAULT-1:0] = fault_q;
        end else if (sel_stat) begin
            rd_word[`MFM_NFAULT-1:0] = irq_stat_q;
        end else if (sel_mask) begin
            rd_word[`MFM_NFAULT-1:0] = irq_mask_q;
        end else if (sel_mode) begin
            rd_word[`MFM_MODE_GATE_BIT] = gate_en_q;
            rd_word[4:0]                = state_q;
        end else if (sel_tmr) begin
            rd_word[15:0] = timer_per_q;
        end
    end

    // Read data is captured in the setup cycle and stands through the access cycle.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_ph) begin
            pslverr <= ~mapped;
            prdata  <= pwrite ? 32'h0000_0000 : rd_word;
        end
    end
endmodule

// ### design/mfm_tick_gen.v
// Periodic enable generator: one-cycle pulse every COUNT clock cycles.
// Assumes a single clock domain and an asynchronous active-low reset.
`timescale 1ns/100ps

module mfm_tick_gen #(
    parameter [15:0] COUNT = 16'd5000
) (
    input  wire        pclk,
    input  wire        presetn,
    output reg         tick_q
);
    reg [15:0] cnt_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q  <= 16'h0000;
            tick_q <= 1'b0;
        end else if (cnt_q == COUNT - 16'd1) begin
            cnt_q  <= 16'h0000;
            tick_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 16'd1;
            tick_q <= 1'b0;
        end
    end
endmodule

// ### inc/mfm_defines.vh
// Shared constants of the motor drive fault monitor: register offsets, field
// positions, reset values, conversion scales, limits and timing figures.
// Assumes inclusion by bare name from every design file of the block.
`ifndef MFM_DEFINES_VH
`define MFM_DEFINES_VH

// APB byte offsets, one aligned 32-bit word each.
`define MFM_ADDR_OPER       12'h000
`define MFM_ADDR_FAULT      12'h004
`define MFM_ADDR_IRQ_STAT   12'h008
`define MFM_ADDR_IRQ_MASK   12'h00c
`define MFM_ADDR_MODE       12'h010
`define MFM_ADDR_TIMER      12'h014

// Bits of motor_operation_word.
`define MFM_OP_RUN          0
`define MFM_OP_TIMED        1
`define MFM_OP_ERR_RESET    2
`define MFM_OP_W            3

// Fault bit positions, shared by the fault latch, status and mask words.
`define MFM_F_HW_OC         0
`define MFM_F_OC            1
`define MFM_F_OV            2
`define MFM_F_UV            3
`define MFM_F_SPEED         4
`define MFM_F_OVERLOAD      5
`define MFM_F_DRY           6
`define MFM_NFAULT          7

// Bit of the mode word that shows the gate enable.
`define MFM_MODE_GATE_BIT   8

// Reset values.
`define MFM_OPER_RST        3'h0
`define MFM_MASK_RST        7'h00
`define MFM_TIMER_RST       16'h03e8

// Timing figures.
`define MFM_CLK_NS          25
`define MFM_TICK_NS         125000
`define MFM_LOOP_NS         1000000
`define MFM_TICK_CYCLES     16'd5000
`define MFM_LOOP_CYCLES     16'd40000

// Converter scales: 12-bit codes, currents span -50 A..50 A, voltage 0..686.5 V.
`define MFM_ADC_FULL        4095
`define MFM_ADC_MID         12'h800
`define MFM_I_SPAN_A        100
`define MFM_V_SPAN_DV       6865

// Protection limits.
`define MFM_OC_LIMIT_A      7
`define MFM_OV_LIMIT_DV     4200
`define MFM_UV_LIMIT_DV     0
`define MFM_SPD_LIMIT_RADS  490
`define MFM_OL_LIMIT_A      6
`define MFM_DRY_I_A         1
`define MFM_DRY_RPM         2000

`endif

// ### tb/mfm_fault_monitor_props.sv
// Concurrent checks on the ports of the fault monitor.
// Assumes binding to mfm_fault_monitor, one clock and an active-low reset.
`timescale 1ns/100ps
module mfm_fault_monitor_props #(
    parameter [15:0] TICK_CYCLES = 16'd5000,
    parameter [15:0] LOOP_CYCLES = 16'd40000
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        hw_oc_n,
    input wire logic [11:0] cur_u,
    input wire logic [11:0] cur_v,
    input wire logic [11:0] cur_w,
    input wire logic [11:0] bus_volt,
    input wire logic [15:0] speed_rads,
    input wire logic [15:0] speed_rpm,
    input wire logic [11:0] cur_result,
    input wire logic [5:0]  pwm_in,
    input wire logic [5:0]  pwm_out,
    input wire logic [5:0]  pwm_oe,
    input wire logic        wdt_kick
);
    logic        samp_bad;
    logic        app_bad;
    logic [15:0] samp_q;
    logic [15:0] app_q;
    logic [15:0] gap_q;
    // A limit breach must persist past one whole tick period (loop period for the application checks) before a stop is owed.
    assign samp_bad = cur_u > 12'd2334 || cur_u < 12'd1762 || cur_v > 12'd2334
        || cur_v < 12'd1762 || cur_w > 12'd2334 || cur_w < 12'd1762 || bus_volt > 12'd2505
        || $signed(speed_rads) > 16'sd490 || $signed(speed_rads) < -16'sd490;
    assign app_bad = cur_result >= 12'd246 || (speed_rpm >= 16'd2000 && cur_result <= 12'd40);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            samp_q <= 16'h0000;
            app_q  <= 16'h0000;
            gap_q  <= 16'h0000;
        end else begin
            samp_q <= samp_bad ? samp_q + 16'h0001 : 16'h0000;
            app_q  <= app_bad ? app_q + 16'h0001 : 16'h0000;
            gap_q  <= wdt_kick ? 16'h0000 : gap_q + 16'h0001;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_trip;
        !hw_oc_n;
    endsequence
    sequence s_calm;
        (hw_oc_n && !psel)[*4];
    endsequence
    AST_OE_OFF: assert property (s_trip |-> pwm_oe == 6'h00)
        else $error("gate enables on during overcurrent");
    AST_OE_ON: assert property (hw_oc_n |-> pwm_oe == 6'h3f)
        else $error("gate enables off without overcurrent");
    AST_HW_STOP: assert property (s_trip |=> pwm_out == 6'h00)
        else $error("gates active after overcurrent");
    AST_LATCH: assert property (s_trip ##1 s_calm |-> pwm_out == 6'h00)
        else $error("gates resumed without error reset");
    AST_SAMPLED: assert property (samp_q > TICK_CYCLES + 16'd2 |-> pwm_out == 6'h00)
        else $error("sampled limit breach did not stop gates");
    AST_APP: assert property (app_q > LOOP_CYCLES + 16'd2 |-> pwm_out == 6'h00)
        else $error("overload or dry running did not stop gates");
    AST_WDT: assert property (gap_q < LOOP_CYCLES + 16'd3)
        else $error("watchdog service missed");
    AST_PASS: assert property (pwm_out != 6'h00 |-> pwm_out == $past(pwm_in))
        else $error("gate output not a delayed command");
endmodule

bind mfm_fault_monitor mfm_fault_monitor_props #(
    .TICK_CYCLES(TICK_CYCLES), .LOOP_CYCLES(LOOP_CYCLES)) i_mfm_fault_monitor_props (
    .pclk, .presetn, .psel, .hw_oc_n, .cur_u, .cur_v, .cur_w, .bus_volt, .speed_rads,
    .speed_rpm, .cur_result, .pwm_in, .pwm_out, .pwm_oe, .wdt_kick);

// ### tb/mfm_power_stage.sv
// Behavioural inverter power stage with current, voltage and speed sensing.
// Assumes fault_sel and jit change just after rising pclk edges.
`timescale 1ns/100ps
module mfm_power_stage (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [3:0]  fault_sel,
    input  wire logic [7:0]  jit,
    output logic             hw_oc_n,
    output logic [11:0]      cur_u,
    output logic [11:0]      cur_v,
    output logic [11:0]      cur_w,
    output logic [11:0]      bus_volt,
    output logic [15:0]      speed_rads,
    output logic [15:0]      speed_rpm,
    output logic [11:0]      cur_result,
    output logic [5:0]       pwm_in
);
    wire edge_case = fault_sel == 4'h8;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_in <= 6'h21;
        end else begin
            pwm_in <= {pwm_in[4:0], pwm_in[5]};
        end
    end
    // Case 8 holds cur_v, cur_w, bus voltage, speed and resultant current one code inside their limits, so nothing may trip.
    always_comb begin
        hw_oc_n    = fault_sel != 4'h1;
        cur_u      = 12'h800 + {4'h0, jit};
        cur_v      = fault_sel == 4'h2 ? 12'd2335 : edge_case ? 12'd2334 : 12'h800;
        cur_w      = fault_sel == 4'h3 ? 12'd1761 : edge_case ? 12'd1762 : 12'h800;
        bus_volt   = fault_sel == 4'h4 ? 12'd2506 : edge_case ? 12'd2505 : 12'h600 + jit;
        speed_rads = fault_sel == 4'h5 ? 16'hfe15 : edge_case ? 16'd490 : 16'd200 + jit;
        speed_rpm  = fault_sel >= 4'h7 ? 16'd2000 : 16'd1500;
        cur_result = fault_sel == 4'h6 ? 12'd246 : fault_sel == 4'h7 ? 12'd40
            : edge_case ? 12'd245 : 12'd60 + jit[6:0];
    end
endmodule

// ### tb/tb_top.sv
// Self-checking bench of the fault monitor driven over APB.
// Assumes the power stage model supplies all sensed quantities.
`timescale 1ns/100ps
`include "mfm_defines.vh"
module tb_top;
    localparam [15:0] LOOP = 16'd32;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, hw_oc_n, wdt_kick;
    logic        irq, rerr;
    logic [11:0] paddr, cur_u, cur_v, cur_w, bus_volt, cur_result;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] speed_rads, speed_rpm, tv;
    logic [5:0]  pwm_in, pwm_out, pwm_oe;
    logic [3:0]  fault_sel;
    logic [7:0]  jit;
    logic [6:0]  mask, fbit;
    int          num_errors, tests_run, s;

    mfm_fault_monitor #(.TICK_CYCLES(16'd8), .LOOP_CYCLES(LOOP)) i_mfm_fault_monitor (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .hw_oc_n(hw_oc_n), .cur_u(cur_u), .cur_v(cur_v), .cur_w(cur_w), .bus_volt(bus_volt),
        .speed_rads(speed_rads), .speed_rpm(speed_rpm), .cur_result(cur_result),
        .pwm_in(pwm_in), .pwm_out(pwm_out), .pwm_oe(pwm_oe), .wdt_kick(wdt_kick), .irq(irq));
    mfm_power_stage i_mfm_power_stage (
        .pclk(pclk), .presetn(presetn), .fault_sel(fault_sel), .jit(jit), .hw_oc_n(hw_oc_n),
        .cur_u(cur_u), .cur_v(cur_v), .cur_w(cur_w), .bus_volt(bus_volt),
        .speed_rads(speed_rads), .speed_rpm(speed_rpm), .cur_result(cur_result),
        .pwm_in(pwm_in));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n == 0 || (pready !== 1'b1 && n < 64); n++)
            @(posedge pclk);
        if (pready !== 1'b1)
            num_errors++;
        rd = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // Timed-phase changes wait on loop ticks, so poll instead of assuming a latency.
    task automatic wait_mode(input logic [31:0] exp);
        int n;
        for (n = 0; n < 100 && rd !== exp; n++)
            apb(1'b0, `MFM_ADDR_MODE, 32'h0);
        chk(rd, exp);
    endtask
    function automatic logic [6:0] bit_of(input int c);
        case (c)
            1: bit_of = 7'h01 << `MFM_F_HW_OC;
            2, 3: bit_of = 7'h01 << `MFM_F_OC;
            4: bit_of = 7'h01 << `MFM_F_OV;
            5: bit_of = 7'h01 << `MFM_F_SPEED;
            6: bit_of = 7'h01 << `MFM_F_OVERLOAD;
            7: bit_of = 7'h01 << `MFM_F_DRY;
            default: bit_of = 7'h00;
        endcase
    endfunction
    task automatic final_report;
        if (num_errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk) jit <= 8'($urandom);
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        final_report();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, fault_sel} = '0;
        num_errors = 0;
        tests_run = 0;
        void'($urandom(30546));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(`MFM_ADDR_OPER, 32'h0);
        rchk(`MFM_ADDR_FAULT, 32'h0);
        rchk(12'h018, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        wait_mode(32'h001);
        rchk(`MFM_ADDR_TIMER, 32'h3e8);
        tv = 16'($urandom);
        apb(1'b1, `MFM_ADDR_TIMER, {16'h0, tv});
        rchk(`MFM_ADDR_TIMER, {16'h0, tv});
        for (s = 1; s <= 8; s++) begin
            mask = 7'($urandom);
            fbit = bit_of(s);
            apb(1'b1, `MFM_ADDR_IRQ_MASK, {25'h0, mask});
            apb(1'b1, `MFM_ADDR_OPER, 32'h1);
            wait_mode(32'h102);
            fault_sel <= s[3:0];
            repeat (2) @(posedge pclk);
            chk({26'h0, pwm_oe}, s == 1 ? 32'h0 : 32'h3f);
            repeat (LOOP + 8) @(posedge pclk);
            fault_sel <= 4'h0;
            repeat (LOOP + 8) @(posedge pclk);
            chk({31'h0, pwm_out == 6'h00}, {31'h0, fbit != 7'h00});
            rchk(`MFM_ADDR_FAULT, {25'h0, fbit});
            rchk(`MFM_ADDR_MODE, fbit != 7'h00 ? 32'h010 : 32'h102);
            chk({31'h0, irq}, {31'h0, |(mask & fbit)});
            apb(1'b1, `MFM_ADDR_IRQ_STAT, {25'h0, fbit});
            chk({31'h0, irq}, 32'h0);
            apb(1'b1, `MFM_ADDR_OPER, 32'h0);
            apb(1'b1, `MFM_ADDR_OPER, 32'h4);
            rchk(`MFM_ADDR_FAULT, 32'h0);
            wait_mode(32'h001);
        end
        apb(1'b1, `MFM_ADDR_TIMER, 32'h2);
        apb(1'b1, `MFM_ADDR_OPER, 32'h3);
        wait_mode(32'h104);
        wait_mode(32'h008);
        final_report();
    end
endmodule
